//--- src/tmh_cfg.svh
// Register indices, region bases, reset values, field masks and timing of the address map.
`ifndef TMH_CFG_SVH
`define TMH_CFG_SVH

`define TMH_IDX_RUN_CTRL    5'h00
`define TMH_IDX_STATUS      5'h01
`define TMH_IDX_EVT_EN      5'h02
`define TMH_IDX_EVT_FLAGS   5'h03
`define TMH_IDX_CONFIG      5'h04
`define TMH_IDX_CLK_DIV     5'h05
`define TMH_IDX_LFSR_EXP    5'h07
`define TMH_IDX_SEED_LO     5'h08
`define TMH_IDX_SEED_HI     5'h09
`define TMH_IDX_RES_LO      5'h0A
`define TMH_IDX_RES_HI      5'h0B
`define TMH_IDX_PTR_LOAD    5'h0C
`define TMH_IDX_SCAN_OUT    5'h0D
`define TMH_IDX_SCAN_IN     5'h0E
`define TMH_IDX_EXPECTED    5'h0F
`define TMH_IDX_MASK        5'h10
`define TMH_IDX_VEC_PTR     5'h11
`define TMH_IDX_VECTOR      5'h12
`define TMH_IDX_HT_PTR      5'h13
`define TMH_IDX_HDR_TRL     5'h14
`define TMH_IDX_MAC_PTR     5'h15
`define TMH_IDX_MACRO       5'h16
`define TMH_IDX_SEQ_PTR     5'h17
`define TMH_IDX_SEQUENCER   5'h18
`define TMH_IDX_BRG_PTR     5'h19
`define TMH_IDX_BRIDGE      5'h1A

`define TMH_BASE_SCAN_OUT   11'h000
`define TMH_BASE_SCAN_IN    11'h1C0
`define TMH_BASE_EXPECTED   11'h380
`define TMH_BASE_MASK       11'h540
`define TMH_BASE_VECTOR     11'h700
`define TMH_BASE_HDR_TRL    11'h708
`define TMH_BASE_MACRO      11'h788
`define TMH_BASE_SEQUENCER  11'h798
`define TMH_BASE_BRIDGE     11'h7B8

`define TMH_RST_ZERO        16'h0000
`define TMH_RST_CONFIG      16'h0043

`define TMH_MASK_RUN_CTRL   16'h001F
`define TMH_MASK_STATUS     16'h03FF
`define TMH_MASK_EVT        16'h00FF
`define TMH_MASK_CONFIG     16'h00FF
`define TMH_MASK_CLK_DIV    16'h003F
`define TMH_MASK_LFSR_EXP   16'h0007

`define TMH_RD_LATENCY      2

`endif

//--- src/tmh_pkg.sv
// Types shared by the address map and its memory.
package tmh_pkg;
  typedef enum logic [3:0] {
    TMH_RGN_SCAN_OUT  = 4'b0000,
    TMH_RGN_SCAN_IN   = 4'b0001,
    TMH_RGN_EXPECTED  = 4'b0010,
    TMH_RGN_MASK      = 4'b0011,
    TMH_RGN_VECTOR    = 4'b0100,
    TMH_RGN_HDR_TRL   = 4'b0101,
    TMH_RGN_MACRO     = 4'b0110,
    TMH_RGN_SEQUENCER = 4'b0111,
    TMH_RGN_BRIDGE    = 4'b1000,
    TMH_RGN_NONE      = 4'b1111
  } tmh_region_t;
endpackage

//--- src/tmh_dual_port_mem.sv
// Dual-port word memory shared by the host side and the scan side.
module tmh_dual_port_mem import tmh_pkg::*; #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11,
  parameter int DW    = 32
) (
  // Clock.
  input  wire logic          sys_clk,
  // Host port.
  input  wire logic          a_en,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  // Scan port.
  input  wire logic          b_en,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_wdata,
  output logic      [DW-1:0] b_rdata
);
  logic [DW-1:0] mem_array [0:DEPTH-1];

  // Each port reads and writes on its own, one clock after the address.
  // One process holds the array so it has a single driver; the scan side wins a collision.
  always_ff @(posedge sys_clk) begin
    if (a_en && a_we) begin
      mem_array[a_addr] <= a_wdata;
    end
    if (b_en && b_we) begin
      mem_array[b_addr] <= b_wdata;
    end
    if (a_en) begin
      a_rdata <= mem_array[a_addr];
    end
    if (b_en) begin
      b_rdata <= mem_array[b_addr];
    end
  end
endmodule

//--- src/tmh_address_map.sv
// Register bank and region address decoder of the test master, reached over AXI4-Lite.
//
// Added by the designer: the AXI4-Lite register port.
`include "tmh_cfg.svh"

module tmh_address_map import tmh_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int MEM_DEPTH = 2048,
  parameter int MEM_AW = 11
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Control values handed to the scan engine.
  output logic [15:0]            run_control,
  output logic [15:0]            device_status,
  output logic [15:0]            event_enable_control,
  output logic [15:0]            event_flags,
  output logic [15:0]            device_configuration,
  output logic [15:0]            scan_clock_divider,
  output logic [2:0]             signature_lfsr_exponent,
  output logic [31:0]            signature_seed,
  // Signature result from the scan engine.
  input  wire logic              sig_result_load,
  input  wire logic [31:0]       sig_result_value,
  // Scan side memory port.
  input  wire logic              scan_mem_en,
  input  wire logic              scan_mem_we,
  input  wire logic [MEM_AW-1:0] scan_mem_addr,
  input  wire logic [31:0]       scan_mem_wdata,
  output logic [31:0]            scan_mem_rdata
);
  localparam int NRGN = 9;
  localparam logic [10:0] RGN_BASE [0:NRGN-1] = '{`TMH_BASE_SCAN_OUT, `TMH_BASE_SCAN_IN,
    `TMH_BASE_EXPECTED, `TMH_BASE_MASK, `TMH_BASE_VECTOR, `TMH_BASE_HDR_TRL,
    `TMH_BASE_MACRO, `TMH_BASE_SEQUENCER, `TMH_BASE_BRIDGE};
  localparam logic [4:0] RGN_PTR_IDX [0:NRGN-1] = '{`TMH_IDX_PTR_LOAD, `TMH_IDX_PTR_LOAD,
    `TMH_IDX_PTR_LOAD, `TMH_IDX_PTR_LOAD, `TMH_IDX_VEC_PTR, `TMH_IDX_HT_PTR,
    `TMH_IDX_MAC_PTR, `TMH_IDX_SEQ_PTR, `TMH_IDX_BRG_PTR};

  logic [15:0]       run_ctrl_reg;
  logic [15:0]       status_reg;
  logic [15:0]       evt_en_reg;
  logic [15:0]       evt_flags_reg;
  logic [15:0]       config_reg;
  logic [15:0]       clk_div_reg;
  logic [15:0]       lfsr_exp_reg;
  logic [15:0]       seed_lo_reg;
  logic [31:0]       seed_reg;
  logic [15:0]       res_lo_reg;
  logic [31:0]       result_reg;
  logic [15:0]       res_snap_reg;
  logic [15:0]       ptr_load_reg;
  logic [15:0]       ptr_reg [0:NRGN-1];
  logic              half_reg;
  logic [15:0]       stage_lo_reg;
  logic [15:0]       mem_snap_reg;
  logic              bvalid_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic              rd_pend_reg;
  logic [4:0]        rd_idx_reg;
  logic              rd_ok_reg;
  logic              rd_half_reg;
  tmh_region_t       rd_rgn_reg;
  logic [31:0]       mem_q;

  // Channel handshakes: a write needs address and data together and wins over a read.
  wire              wr_pair   = s_axi_awvalid & s_axi_wvalid;
  wire              wr_fire   = wr_pair & ~bvalid_reg & ~rd_pend_reg;
  wire              rd_fire   = s_axi_arvalid & ~rvalid_reg & ~rd_pend_reg & ~wr_pair;
  wire [4:0]        wr_idx    = s_axi_awaddr[6:2];
  wire [4:0]        rd_idx    = s_axi_araddr[6:2];
  wire              wr_ok     = (s_axi_awaddr[ADDR_W-1:7] == '0) && (|s_axi_wstrb[1:0]);
  wire              rd_ok     = (s_axi_araddr[ADDR_W-1:7] == '0);
  wire [15:0]       wd        = s_axi_wdata[15:0];
  wire [4:0]        acc_idx   = wr_fire ? wr_idx : rd_idx;
  wire              acc_ok    = wr_fire ? wr_ok : rd_ok;

  // Region decode of the current access.
  wire tmh_region_t acc_rgn   = !acc_ok ? TMH_RGN_NONE :
                                (acc_idx == `TMH_IDX_SCAN_OUT)  ? TMH_RGN_SCAN_OUT :
                                (acc_idx == `TMH_IDX_SCAN_IN)   ? TMH_RGN_SCAN_IN :
                                (acc_idx == `TMH_IDX_EXPECTED)  ? TMH_RGN_EXPECTED :
                                (acc_idx == `TMH_IDX_MASK)      ? TMH_RGN_MASK :
                                (acc_idx == `TMH_IDX_VECTOR)    ? TMH_RGN_VECTOR :
                                (acc_idx == `TMH_IDX_HDR_TRL)   ? TMH_RGN_HDR_TRL :
                                (acc_idx == `TMH_IDX_MACRO)     ? TMH_RGN_MACRO :
                                (acc_idx == `TMH_IDX_SEQUENCER) ? TMH_RGN_SEQUENCER :
                                (acc_idx == `TMH_IDX_BRIDGE)    ? TMH_RGN_BRIDGE : TMH_RGN_NONE;
  wire              acc_mem   = (acc_rgn != TMH_RGN_NONE);
  wire [3:0]        rgn_sel   = acc_mem ? acc_rgn : 4'h0;
  wire [15:0]       sel_ptr   = ptr_reg[rgn_sel];
  wire [MEM_AW-1:0] mem_addr  = MEM_AW'(RGN_BASE[rgn_sel] + sel_ptr[10:0]);
  wire              vec_pad   = (acc_rgn == TMH_RGN_VECTOR) && sel_ptr[0];
  wire [15:0]       wr_hi     = vec_pad ? 16'h0000 : wd;
  wire              mem_en    = (wr_fire | rd_fire) & acc_mem;
  wire              mem_we    = wr_fire & acc_mem & half_reg;
  wire [31:0]       mem_wdata = {wr_hi, stage_lo_reg};
  wire              rd_mem    = rd_pend_reg & (rd_rgn_reg != TMH_RGN_NONE);
  wire              wr_reg    = wr_fire & wr_ok;

  // Dual-port buffer holding every region.
  tmh_dual_port_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW),
    .DW    (32)
  ) u_mem (
    .sys_clk (sys_clk),
    .a_en    (mem_en),
    .a_we    (mem_we),
    .a_addr  (mem_addr),
    .a_wdata (mem_wdata),
    .a_rdata (mem_q),
    .b_en    (scan_mem_en),
    .b_we    (scan_mem_we),
    .b_addr  (scan_mem_addr),
    .b_wdata (scan_mem_wdata),
    .b_rdata (scan_mem_rdata)
  );

  // Pointers: loaded from their index register, data pointers step once per long word.
  genvar gi;
  generate
    for (gi = 0; gi < NRGN; gi++) begin : g_ptr
      wire load_w = wr_reg && (wr_idx == RGN_PTR_IDX[gi]);
      wire step_w = (gi == 1) ?
                    (rd_pend_reg && rd_half_reg && (rd_rgn_reg == TMH_RGN_SCAN_IN)) :
                    (gi < 4) && wr_fire && half_reg && (acc_rgn == tmh_region_t'(gi));
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          ptr_reg[gi] <= `TMH_RST_ZERO;
        end else if (load_w) begin
          ptr_reg[gi] <= wd;
        end else if (step_w) begin
          ptr_reg[gi] <= ptr_reg[gi] + 16'h0001;
        end
      end
    end
  endgenerate

  // Half-word sequencing of memory accesses; a pointer load restarts the pair.
  wire ptr_wr = wr_reg && ((wr_idx == `TMH_IDX_PTR_LOAD) || (wr_idx == `TMH_IDX_VEC_PTR) ||
                (wr_idx == `TMH_IDX_HT_PTR) || (wr_idx == `TMH_IDX_MAC_PTR) ||
                (wr_idx == `TMH_IDX_SEQ_PTR) || (wr_idx == `TMH_IDX_BRG_PTR));
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      half_reg     <= 1'b0;
      stage_lo_reg <= `TMH_RST_ZERO;
    end else if (ptr_wr) begin
      half_reg     <= 1'b0;
    end else if (mem_en) begin
      half_reg     <= ~half_reg;
      if (wr_fire && !half_reg) begin
        stage_lo_reg <= wd;
      end
    end
  end

  // Plain control registers, only their active bits are kept; the pointer load register keeps all 16 bits.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_ctrl_reg  <= `TMH_RST_ZERO;
      status_reg    <= `TMH_RST_ZERO;
      evt_en_reg    <= `TMH_RST_ZERO;
      evt_flags_reg <= `TMH_RST_ZERO;
      config_reg    <= `TMH_RST_CONFIG;
      clk_div_reg   <= `TMH_RST_ZERO;
      lfsr_exp_reg  <= `TMH_RST_ZERO;
      ptr_load_reg  <= `TMH_RST_ZERO;
    end else if (wr_reg) begin
      case (wr_idx)
        `TMH_IDX_RUN_CTRL:  run_ctrl_reg  <= wd & `TMH_MASK_RUN_CTRL;
        `TMH_IDX_STATUS:    status_reg    <= wd & `TMH_MASK_STATUS;
        `TMH_IDX_EVT_EN:    evt_en_reg    <= wd & `TMH_MASK_EVT;
        `TMH_IDX_EVT_FLAGS: evt_flags_reg <= wd & `TMH_MASK_EVT;
        `TMH_IDX_CONFIG:    config_reg    <= wd & `TMH_MASK_CONFIG;
        `TMH_IDX_CLK_DIV:   clk_div_reg   <= wd & `TMH_MASK_CLK_DIV;
        `TMH_IDX_LFSR_EXP:  lfsr_exp_reg  <= wd & `TMH_MASK_LFSR_EXP;
        `TMH_IDX_PTR_LOAD:  ptr_load_reg  <= wd;
        default:            ptr_load_reg  <= ptr_load_reg;
      endcase
    end
  end

  // Signature seed and result, joined from a low then high half access.
  wire res_rd_lo = rd_fire && rd_ok && (rd_idx == `TMH_IDX_RES_LO);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seed_lo_reg  <= `TMH_RST_ZERO;
      seed_reg     <= 32'h0000_0000;
      res_lo_reg   <= `TMH_RST_ZERO;
      result_reg   <= 32'h0000_0000;
      res_snap_reg <= `TMH_RST_ZERO;
    end else begin
      if (wr_reg && (wr_idx == `TMH_IDX_SEED_LO)) begin
        seed_lo_reg <= wd;
      end
      if (wr_reg && (wr_idx == `TMH_IDX_SEED_HI)) begin
        seed_reg <= {wd, seed_lo_reg};
      end
      if (wr_reg && (wr_idx == `TMH_IDX_RES_LO)) begin
        res_lo_reg <= wd;
      end
      if (sig_result_load) begin
        result_reg <= sig_result_value;
      end else if (wr_reg && (wr_idx == `TMH_IDX_RES_HI)) begin
        result_reg <= {wd, res_lo_reg};
      end
      if (res_rd_lo) begin
        res_snap_reg <= result_reg[31:16];
      end
    end
  end

  // Register read selection; unassigned indices answer zero.
  wire [15:0] reg_rdata =
    !rd_ok_reg                          ? 16'h0000 :
    (rd_idx_reg == `TMH_IDX_RUN_CTRL)  ? run_ctrl_reg :
    (rd_idx_reg == `TMH_IDX_STATUS)    ? status_reg :
    (rd_idx_reg == `TMH_IDX_EVT_EN)    ? evt_en_reg :
    (rd_idx_reg == `TMH_IDX_EVT_FLAGS) ? evt_flags_reg :
    (rd_idx_reg == `TMH_IDX_CONFIG)    ? config_reg :
    (rd_idx_reg == `TMH_IDX_CLK_DIV)   ? clk_div_reg :
    (rd_idx_reg == `TMH_IDX_LFSR_EXP)  ? lfsr_exp_reg :
    (rd_idx_reg == `TMH_IDX_SEED_LO)   ? seed_reg[15:0] :
    (rd_idx_reg == `TMH_IDX_SEED_HI)   ? seed_reg[31:16] :
    (rd_idx_reg == `TMH_IDX_RES_LO)    ? result_reg[15:0] :
    (rd_idx_reg == `TMH_IDX_RES_HI)    ? res_snap_reg :
    (rd_idx_reg == `TMH_IDX_PTR_LOAD)  ? ptr_load_reg :
    (rd_idx_reg == `TMH_IDX_VEC_PTR)   ? ptr_reg[4] :
    (rd_idx_reg == `TMH_IDX_HT_PTR)    ? ptr_reg[5] :
    (rd_idx_reg == `TMH_IDX_MAC_PTR)   ? ptr_reg[6] :
    (rd_idx_reg == `TMH_IDX_SEQ_PTR)   ? ptr_reg[7] :
    (rd_idx_reg == `TMH_IDX_BRG_PTR)   ? ptr_reg[8] : 16'h0000;
  wire [15:0] mem_half  = rd_half_reg ? mem_snap_reg : mem_q[15:0];
  wire [15:0] rd_value  = rd_mem ? mem_half : reg_rdata;

  // Read channel: take the address, one cycle for the memory, then answer.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_pend_reg  <= 1'b0;
      rd_idx_reg   <= 5'h00;
      rd_ok_reg    <= 1'b0;
      rd_half_reg  <= 1'b0;
      rd_rgn_reg   <= TMH_RGN_NONE;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      mem_snap_reg <= `TMH_RST_ZERO;
    end else begin
      rd_pend_reg <= rd_fire;
      if (rd_fire) begin
        rd_idx_reg  <= rd_idx;
        rd_ok_reg   <= rd_ok;
        rd_half_reg <= half_reg;
        rd_rgn_reg  <= acc_rgn;
      end
      if (rd_mem && !rd_half_reg) begin
        mem_snap_reg <= mem_q[31:16];
      end
      if (rd_pend_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {16'h0000, rd_value};
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Write response follows the taken pair by one cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready           = wr_fire;
  assign s_axi_wready            = wr_fire;
  assign s_axi_bvalid            = bvalid_reg;
  assign s_axi_bresp             = 2'b00;
  assign s_axi_arready           = rd_fire;
  assign s_axi_rvalid            = rvalid_reg;
  assign s_axi_rdata             = rdata_reg;
  assign s_axi_rresp             = 2'b00;
  assign run_control             = run_ctrl_reg;
  assign device_status           = status_reg;
  assign event_enable_control    = evt_en_reg;
  assign event_flags             = evt_flags_reg;
  assign device_configuration    = config_reg;
  assign scan_clock_divider      = clk_div_reg;
  assign signature_lfsr_exponent = lfsr_exp_reg[2:0];
  assign signature_seed          = seed_reg;

  // Checks kept beside the logic.
  seed_pair_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_reg && (wr_idx == `TMH_IDX_SEED_HI) |=>
      signature_seed == {$past(wd), $past(seed_lo_reg)})
    else $error("Seed not joined from both halves.");
  mem_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_fire && (acc_rgn == TMH_RGN_EXPECTED) |->
      mem_addr == MEM_AW'(`TMH_BASE_EXPECTED + ptr_reg[2][10:0]))
    else $error("Memory address is not base plus pointer.");
  load_all_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_reg && (wr_idx == `TMH_IDX_PTR_LOAD) |=>
      (ptr_reg[0] == $past(wd)) && (ptr_reg[1] == $past(wd)) &&
      (ptr_reg[2] == $past(wd)) && (ptr_reg[3] == $past(wd)))
    else $error("Data pointers not all loaded.");
  wr_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_fire && half_reg && (acc_rgn == TMH_RGN_MASK) |=>
      ptr_reg[3] == $past(ptr_reg[3]) + 16'h0001)
    else $error("Mask pointer did not step after a word.");
  rd_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_fire && half_reg && (acc_rgn == TMH_RGN_SCAN_IN) |=> ##1
      ptr_reg[1] == $past(ptr_reg[1], 2) + 16'h0001)
    else $error("Capture pointer did not step after a word.");
  ptr_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !wr_fire && !rd_pend_reg |=> ptr_reg[2] == $past(ptr_reg[2]))
    else $error("Pointer changed without load or step.");
  vec_pad_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mem_we && vec_pad |-> mem_wdata[31:16] == 16'h0000)
    else $error("Vector padding bytes were stored.");
  exp_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_fire && rd_ok && (rd_idx == `TMH_IDX_LFSR_EXP) |=> ##1 s_axi_rdata[31:3] == '0)
    else $error("Exponent shows more than three bits.");
  unmapped_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_fire && !rd_ok |=> ##1 s_axi_rvalid && (s_axi_rdata == 32'h0000_0000))
    else $error("Unmapped read did not answer zero.");
endmodule

//--- tb/tmh_scan_side_model.sv
// Scan engine model driving the scan side memory port and the signature result.
module tmh_scan_side_model (
  // Clock.
  input  wire logic        sys_clk,
  // Scan side memory port.
  output logic             scan_mem_en,
  output logic             scan_mem_we,
  output logic [10:0]      scan_mem_addr,
  output logic [31:0]      scan_mem_wdata,
  input  wire logic [31:0] scan_mem_rdata,
  // Signature result.
  output logic             sig_result_load,
  output logic [31:0]      sig_result_value
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scan_mem_en = 1'b0;
    scan_mem_we = 1'b0;
    scan_mem_addr = 11'h000;
    scan_mem_wdata = 32'h0000_0000;
    sig_result_load = 1'b0;
    sig_result_value = 32'h0000_0000;
  end
  // One word access; released address and data lines show the inverse of their last value, enable and write go low.
  task automatic access(input logic we, input logic [10:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge sys_clk);
    scan_mem_en <= 1'b1;
    scan_mem_we <= we;
    scan_mem_addr <= a;
    scan_mem_wdata <= d;
    @(posedge sys_clk);
    scan_mem_en <= 1'b0;
    scan_mem_we <= 1'b0;
    scan_mem_addr <= ~a;
    scan_mem_wdata <= ~d;
    @(posedge sys_clk);
    q = scan_mem_rdata;
  endtask
  // The result is handed over as one whole 32-bit value.
  task automatic load_result(input logic [31:0] v);
    @(posedge sys_clk);
    sig_result_load <= 1'b1;
    sig_result_value <= v;
    @(posedge sys_clk);
    sig_result_load <= 1'b0;
    sig_result_value <= ~v;
  endtask
endmodule

//--- tb/test_master_host_address_map_bench.sv
// Self-checking bench of the host address map with a scan engine model.
`include "tmh_cfg.svh"
module test_master_host_address_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, signature_seed, sig_result_value, scan_mem_wdata, scan_mem_rdata;
  logic [15:0] run_control, device_status, event_enable_control, event_flags;
  logic [15:0] device_configuration, scan_clock_divider;
  logic [2:0]  signature_lfsr_exponent;
  logic        sig_result_load, scan_mem_en, scan_mem_we;
  logic [10:0] scan_mem_addr;
  int          err_count = 0;
  int          checks = 0;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr = 32'h64f5;
  logic [4:0]  regs [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09,
                             5'h0A, 5'h0B, 5'h0C, 5'h11, 5'h13, 5'h15, 5'h17, 5'h19};
  logic [15:0] msk [7] = '{`TMH_MASK_RUN_CTRL, `TMH_MASK_STATUS, `TMH_MASK_EVT, `TMH_MASK_EVT,
                           `TMH_MASK_CONFIG, `TMH_MASK_CLK_DIV, `TMH_MASK_LFSR_EXP};
  logic [15:0] wv [7];
  logic [4:0]  dr [3] = '{5'h0D, 5'h0F, 5'h10};
  logic [10:0] db [3] = '{11'h000, 11'h380, 11'h540};
  logic [4:0]  np [5] = '{5'h11, 5'h13, 5'h15, 5'h17, 5'h19};
  logic [10:0] nb [5] = '{11'h700, 11'h708, 11'h788, 11'h798, 11'h7B8};
  logic [15:0] p;
  logic [31:0] w, q;

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  tmh_address_map DUT (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .run_control, .device_status, .event_enable_control,
    .event_flags, .device_configuration, .scan_clock_divider, .signature_lfsr_exponent,
    .signature_seed, .sig_result_load, .sig_result_value, .scan_mem_en, .scan_mem_we,
    .scan_mem_addr, .scan_mem_wdata, .scan_mem_rdata);
  tmh_scan_side_model scan (.sys_clk, .scan_mem_en, .scan_mem_we, .scan_mem_addr,
    .scan_mem_wdata, .scan_mem_rdata, .sig_result_load, .sig_result_value);

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wait_hs(input int which);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      case (which)
        0: hit = s_axi_awready & s_axi_wready;
        1: hit = s_axi_bvalid;
        2: hit = s_axi_arready;
        default: hit = s_axi_rvalid;
      endcase
      if (n >= 50 && hit !== 1'b1) begin
        err_count++;
        $display("ERROR %0t: handshake timeout", $time);
        results();
      end
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {~d, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= {d, ~d};
    wait_hs(1);
    chk({30'h0, s_axi_bresp}, 32'h0000_0000);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hs(2);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    wait_hs(3);
    s_axi_rready <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk(s_axi_rdata, {16'h0000, exp_q.pop_front()});
      chk({30'h0, s_axi_rresp}, 32'h0000_0000);
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk({16'h0000, device_configuration}, 32'h0000_0043);
    foreach (regs[i]) axi_rd({1'b0, regs[i], 2'b00}, (i == 4) ? 16'h0043 : 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wv[i] = rnd();
      axi_wr({1'b0, regs[i], 2'b00}, wv[i]);
      axi_rd({1'b0, regs[i], 2'b00}, wv[i] & msk[i]);
    end
    chk({29'h0, signature_lfsr_exponent}, {29'h0, wv[6][2:0]});
    axi_wr(8'h18, 16'hFFFF);
    axi_wr(8'h6C, 16'hFFFF);
    axi_wr(8'h80, ~wv[0]);
    axi_rd(8'h18, 16'h0000);
    axi_rd(8'h6C, 16'h0000);
    axi_rd(8'h80, 16'h0000);
    axi_rd(8'h00, wv[0] & msk[0]);
    chk({run_control, device_status}, {wv[0] & msk[0], wv[1] & msk[1]});
    chk({event_enable_control, event_flags}, {wv[2] & msk[2], wv[3] & msk[3]});
    chk({device_configuration, scan_clock_divider}, {wv[4] & msk[4], wv[5] & msk[5]});
    axi_wr(8'h20, 16'h1357);
    chk(signature_seed, 32'h0000_0000);
    axi_wr(8'h24, 16'h2468);
    chk(signature_seed, 32'h2468_1357);
    scan.load_result(32'hA5C3_0F96);
    axi_rd(8'h28, 16'h0F96);
    scan.load_result(32'h5A3C_F069);
    axi_rd(8'h2C, 16'hA5C3);
    axi_wr(8'h28, 16'h1111);
    axi_wr(8'h2C, 16'h2222);
    axi_rd(8'h28, 16'h1111);
    axi_rd(8'h2C, 16'h2222);
    p = rnd() & 16'h00FF;
    axi_wr(8'h30, p);
    axi_rd(8'h30, p);
    foreach (dr[k]) begin
      for (int j = 0; j < 2; j++) begin
        w = {rnd(), rnd()};
        axi_wr({1'b0, dr[k], 2'b00}, w[15:0]);
        axi_wr({1'b0, dr[k], 2'b00}, w[31:16]);
        scan.access(1'b0, 11'(db[k] + p[10:0] + j), 32'h0000_0000, q);
        chk(q, w);
      end
    end
    for (int j = 0; j < 2; j++) begin
      w = {rnd(), rnd()};
      scan.access(1'b1, 11'(11'h1C0 + p[10:0] + j), w, q);
      axi_rd(8'h38, w[15:0]);
      axi_rd(8'h38, w[31:16]);
    end
    foreach (np[k]) begin
      p = (k == 0) ? 16'h0001 : (rnd() & 16'h0007);
      w = {rnd(), rnd()};
      axi_wr({1'b0, np[k], 2'b00}, p);
      axi_rd({1'b0, np[k], 2'b00}, p);
      axi_wr({1'b0, np[k] + 5'h01, 2'b00}, w[15:0]);
      axi_wr({1'b0, np[k] + 5'h01, 2'b00}, w[31:16]);
      scan.access(1'b0, 11'(nb[k] + p[10:0]), 32'h0000_0000, q);
      chk(q, (k == 0) ? {16'h0000, w[15:0]} : w);
    end
    results();
  end
endmodule
